// ==== hw/lsd_diag.sv ====
// Chosen here: the APB interface to the registers and the register offsets.
module lsd_diag (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins and analog front end
  input wire logic diag_disable_pin,
  input wire logic enable_reset_pulse,
  input wire logic [5:0] pwm_inputs,
  input wire logic [2:0] freewheel_window,
  input wire lsd_pkg::lsd_comp_t comps,
  output lsd_pkg::lsd_src_t sources,
  output logic fault_out_n
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [lsd_pkg::CYC_W-1:0] us_cyc(input int us);
    us_cyc = lsd_pkg::CYC_W'(us * lsd_pkg::CLK_MHZ);
  endfunction

  function automatic logic [lsd_pkg::CYC_W-1:0] dly_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: dly_cyc = us_cyc(lsd_pkg::DLY_US_0);
      2'h1: dly_cyc = us_cyc(lsd_pkg::DLY_US_1);
      2'h2: dly_cyc = us_cyc(lsd_pkg::DLY_US_2);
      default: dly_cyc = us_cyc(lsd_pkg::DLY_US_3);
    endcase
  endfunction

  // set wins over a clear that lands in the same cycle
  function automatic logic [2:0] keep3(input logic clr, input logic [2:0] old,
                                       input logic [2:0] set);
    keep3 = (clr ? 3'h0 : old) | set;
  endfunction

  function automatic logic keep1(input logic clr, input logic old,
                                 input logic set);
    keep1 = (clr ? 1'b0 : old) | set;
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  lsd_pkg::lsd_state_t state_r, state_nxt;
  logic passive_openload_start_r;
  logic short_test_start_r;
  logic [2:0] active_open_enable_r;
  logic [1:0] diag_duration_select_r;
  logic hw_variant_r;
  logic [2:0] phase_open_flag_r, phase_supply_short_flag_r, phase_ground_short_flag_r;
  logic [2:0] pu_seen_r;
  logic [2:0] ola_arm_r;
  logic [2:0] ola_trip_r;
  logic [1:0] strike_r [3];
  logic fault_r, summary_r, openload_detected_r;
  logic [lsd_pkg::CYC_W-1:0] cnt_r;
  logic [5:0] pwm_q_r;
  logic wake_r;
  logic wake_pend_r;
  logic short_found_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  lsd_pkg::lsd_src_t src_r;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire sel_ctrl = (paddr == lsd_pkg::ADDR_CTRL);
  wire sel_stat = (paddr == lsd_pkg::ADDR_STATUS);
  wire sel_flg = (paddr == lsd_pkg::ADDR_FLAGS);
  // access taken once; pready_r masks the second access edge
  wire acc = psel && penable && !pready_r;
  wire wr = acc && pwrite;
  wire wr_ctrl = wr && sel_ctrl;
  wire hit = sel_ctrl || sel_stat || sel_flg;
  wire clr_cmd = (wr_ctrl && pwdata[lsd_pkg::CTRL_CLR_BIT]) || enable_reset_pulse;
  wire olp_wr_low = wr_ctrl && !pwdata[lsd_pkg::CTRL_OLP_BIT];
  wire in_olp = (state_r == lsd_pkg::ST_OLPU) || (state_r == lsd_pkg::ST_OLPD);
  wire in_sht = (state_r == lsd_pkg::ST_SBAT) || (state_r == lsd_pkg::ST_SGND);
  // any pwm change aborts, even a glitch one cycle wide
  wire input_chg = (pwm_inputs != pwm_q_r);
  wire olp_abort = in_olp && (input_chg || olp_wr_low);
  wire tmo = (cnt_r == '0);
  wire olp_go = passive_openload_start_r && !(hw_variant_r && diag_disable_pin);
  wire wake_olp = hw_variant_r && !diag_disable_pin;
  wire [lsd_pkg::CYC_W-1:0] dur = hw_variant_r ? us_cyc(lsd_pkg::HW_SHORT_US)
                                               : dly_cyc(diag_duration_select_r);
  wire [2:0] open_now = pu_seen_r & comps.pulldown_open_comparator;
  wire [2:0] sb_hit = (state_r == lsd_pkg::ST_SBAT) ? comps.drain_short_comparator : 3'h0;
  wire [2:0] sg_hit = (state_r == lsd_pkg::ST_SGND) ? comps.source_short_comparator : 3'h0;
  wire [2:0] ol_hit = (state_r == lsd_pkg::ST_OLPD && tmo && !olp_abort) ? open_now : 3'h0;
  wire ola_run = hw_variant_r ? !diag_disable_pin : 1'b1;
  wire [2:0] ola_en = hw_variant_r ? {3{ola_run}} : active_open_enable_r;
  wire [2:0] ola_evt;
  wire [2:0] ola_rep;
  // live hits count too, so a short in the last cycle still blocks the passive test
  wire any_short = (|phase_supply_short_flag_r) || (|phase_ground_short_flag_r)
                   || (|sb_hit) || (|sg_hit);
  wire any_open = (|ol_hit) || (|ola_rep);
  wire any_hit = any_open || (|sb_hit) || (|sg_hit);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ola
      // window closes without the overshoot comparator tripping
      assign ola_evt[g] = ola_en[g] && ola_arm_r[g] && !freewheel_window[g]
                          && !ola_trip_r[g] && !comps.overshoot_comparator[g];
      assign ola_rep[g] = ola_evt[g] && (strike_r[g] == 2'(lsd_pkg::NSTRIKE - 1));
    end
  endgenerate

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      lsd_pkg::ST_IDLE:
        if (short_test_start_r || wake_r)
          state_nxt = lsd_pkg::ST_SBAT;
        else if (olp_go)
          state_nxt = lsd_pkg::ST_OLPU;
      lsd_pkg::ST_SBAT:
        if (tmo)
          state_nxt = lsd_pkg::ST_SGND;
      lsd_pkg::ST_SGND:
        if (tmo)
          state_nxt = ((olp_go || wake_olp) && !any_short && !short_found_r) ? lsd_pkg::ST_OLPU
            : lsd_pkg::ST_DONE;
      lsd_pkg::ST_OLPU:
        if (olp_abort)
          state_nxt = lsd_pkg::ST_DONE;
        else if (tmo)
          state_nxt = lsd_pkg::ST_OLPD;
      lsd_pkg::ST_OLPD:
        if (olp_abort || tmo)
          state_nxt = lsd_pkg::ST_DONE;
      lsd_pkg::ST_DONE:
        state_nxt = lsd_pkg::ST_IDLE;
      default:
        state_nxt = lsd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_r <= lsd_pkg::ST_IDLE;
      cnt_r <= '0;
      pwm_q_r <= 6'h00;
      wake_r <= 1'b0;
      short_found_r <= 1'b0;
      pu_seen_r <= 3'h0;
      src_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pwm_q_r <= pwm_inputs;
      // pin variant runs its shorts once after wake, disable pin low
      wake_r <= (state_r == lsd_pkg::ST_IDLE) && hw_variant_r && !diag_disable_pin
                && wake_pend_r;
      // every step reloads the full duration, so pull-up and pull-down take equal time
      if (state_nxt != state_r)
        cnt_r <= dur;
      else if (!tmo)
        cnt_r <= cnt_r - 1'b1;
      if (state_r == lsd_pkg::ST_IDLE && state_nxt == lsd_pkg::ST_SBAT)
        short_found_r <= 1'b0;
      else if (|sb_hit || |sg_hit)
        short_found_r <= 1'b1;
      if (state_r == lsd_pkg::ST_OLPU && tmo)
        pu_seen_r <= comps.pullup_open_comparator;
      src_r.gates_off <= (state_nxt != lsd_pkg::ST_IDLE) && (state_nxt != lsd_pkg::ST_DONE);
      src_r.pullup_src_en <= state_nxt == lsd_pkg::ST_OLPU;
      src_r.pulldown_src_en <= state_nxt == lsd_pkg::ST_OLPD;
      src_r.drain_pd_en <= state_nxt == lsd_pkg::ST_SBAT;
      src_r.source_pu_en <= state_nxt == lsd_pkg::ST_SGND;
    end
  end

  // ************************************************************
  // control bits and fault flags
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      passive_openload_start_r <= 1'b0;
      short_test_start_r <= 1'b0;
      active_open_enable_r <= 3'h0;
      diag_duration_select_r <= 2'h0;
      phase_open_flag_r <= 3'h0;
      phase_supply_short_flag_r <= 3'h0;
      phase_ground_short_flag_r <= 3'h0;
      fault_r <= 1'b0;
      summary_r <= 1'b0;
      openload_detected_r <= 1'b0;
      ola_arm_r <= 3'h0;
      for (int i = 0; i < 3; i++)
        strike_r[i] <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // start bit ignores writes of 1 while running, keeps value
        if (!in_olp || olp_wr_low)
          passive_openload_start_r <= pwdata[lsd_pkg::CTRL_OLP_BIT];
        short_test_start_r <= pwdata[lsd_pkg::CTRL_SHT_BIT];
        active_open_enable_r <= pwdata[lsd_pkg::CTRL_OLA_LSB +: 3];
        diag_duration_select_r <= pwdata[lsd_pkg::CTRL_DLY_LSB +: 2];
      end
      else if (state_r == lsd_pkg::ST_SGND && tmo)
        short_test_start_r <= 1'b0;
      if (olp_abort || (state_r == lsd_pkg::ST_OLPD && tmo)
          || (state_r == lsd_pkg::ST_SGND && tmo && (any_short || short_found_r)))
        passive_openload_start_r <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        ola_arm_r[i] <= freewheel_window[i];
        if (freewheel_window[i] && comps.overshoot_comparator[i])
          strike_r[i] <= 2'h0;
        else if (ola_evt[i] && !ola_rep[i])
          strike_r[i] <= strike_r[i] + 2'h1;
        else if (ola_rep[i])
          strike_r[i] <= 2'h0;
      end
      // set wins over clear
      phase_open_flag_r <= keep3(clr_cmd, phase_open_flag_r, ol_hit | ola_rep);
      phase_supply_short_flag_r <= keep3(clr_cmd, phase_supply_short_flag_r, sb_hit);
      phase_ground_short_flag_r <= keep3(clr_cmd, phase_ground_short_flag_r, sg_hit);
      openload_detected_r <= keep1(clr_cmd, openload_detected_r, any_open);
      summary_r <= keep1(clr_cmd, summary_r, any_hit);
      fault_r <= keep1(clr_cmd, fault_r, any_hit);
    end
  end

  // ************************************************************
  // active open-load window tracking
  // ************************************************************
  // a trip anywhere in the window counts, not only at its closing edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ola_trip_r <= 3'h0;
    else
      for (int i = 0; i < lsd_pkg::NPH; i++)
        ola_trip_r[i] <= freewheel_window[i]
                         && ((ola_arm_r[i] && ola_trip_r[i]) || comps.overshoot_comparator[i]);
  end

  // one diagnostic run per wake; cleared once the supply-short step starts
  // kept pending so a wake run waits for the variant bit
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wake_pend_r <= 1'b1;
    else if (state_r == lsd_pkg::ST_SBAT)
      wake_pend_r <= 1'b0;
  end

  // ************************************************************
  // read mux and bus answer
  // ************************************************************
  wire [31:0] rd_ctrl = {23'h0, hw_variant_r, diag_duration_select_r, active_open_enable_r,
                         short_test_start_r, passive_openload_start_r, 1'b0};
  wire [31:0] rd_stat = {27'h0, state_r != lsd_pkg::ST_IDLE, in_sht, in_olp, summary_r, fault_r};
  wire [31:0] rd_flg = {21'h0, phase_ground_short_flag_r, 1'b0, phase_supply_short_flag_r,
                        openload_detected_r, phase_open_flag_r};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                       sel_stat ? rd_stat :
                       sel_flg ? rd_flg : 32'h0;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      fault_out_n <= 1'b1;
    end
    else
    begin
      // one wait state: pready answers the cycle after the access edge
      pready_r <= acc;
      pslverr_r <= acc && !hit;
      prdata_r <= (acc && !pwrite) ? rd_mux : 32'h0;
      fault_out_n <= !fault_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      hw_variant_r <= 1'b0;
    else if (wr_ctrl)
      hw_variant_r <= pwdata[lsd_pkg::CTRL_HW_BIT];
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sources = src_r;

endmodule // lsd_diag

// ==== hw/lsd_pkg.sv ====
package lsd_pkg;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;

  // control register fields
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_OLP_BIT = 1;
  localparam int CTRL_SHT_BIT = 2;
  localparam int CTRL_OLA_LSB = 3;
  localparam int CTRL_DLY_LSB = 6;
  localparam int CTRL_HW_BIT = 8;

  // status register fields
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_SUM_BIT = 1;
  localparam int STAT_OLP_BIT = 2;
  localparam int STAT_SHT_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;

  // flag register fields
  localparam int FLG_OL_LSB = 0;
  localparam int FLG_SB_LSB = 4;
  localparam int FLG_SG_LSB = 8;

  localparam int NPH = 3;
  localparam int NSTRIKE = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int DLY_US_0 = 250;
  localparam int DLY_US_1 = 1250;
  localparam int DLY_US_2 = 5000;
  localparam int DLY_US_3 = 11500;
  localparam int HW_SHORT_US = 2000;
  localparam int CYC_W = 24;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SBAT = 6'h02,
    ST_SGND = 6'h04,
    ST_OLPU = 6'h08,
    ST_OLPD = 6'h10,
    ST_DONE = 6'h20
  } lsd_state_t;

  typedef struct packed {
    logic [NPH-1:0] pullup_open_comparator;
    logic [NPH-1:0] pulldown_open_comparator;
    logic [NPH-1:0] drain_short_comparator;
    logic [NPH-1:0] source_short_comparator;
    logic [NPH-1:0] overshoot_comparator;
  } lsd_comp_t;

  typedef struct packed {
    logic pullup_src_en;
    logic pulldown_src_en;
    logic drain_pd_en;
    logic source_pu_en;
    logic gates_off;
  } lsd_src_t;

endpackage : lsd_pkg

// ==== tb/load_and_short_diagnostics_bench.sv ====
module load_and_short_diagnostics_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CT = lsd_pkg::ADDR_CTRL;
  localparam logic [7:0] A_ST = lsd_pkg::ADDR_STATUS;
  localparam logic [7:0] A_FL = lsd_pkg::ADDR_FLAGS;
  localparam int STEP = lsd_pkg::DLY_US_0 * lsd_pkg::CLK_MHZ;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enable_reset_pulse = 1'b0;
  logic [5:0] pwm_inputs = 6'h00;
  logic [2:0] freewheel_window = 3'h0;
  logic [2:0] open_pu = 3'h0;
  logic [2:0] open_pd = 3'h0;
  logic [2:0] short_sb = 3'h0;
  logic [2:0] short_sg = 3'h0;
  logic diag_disable_pin = 1'b0;
  logic [2:0] load_ok = 3'h7;
  lsd_pkg::lsd_comp_t comps;
  lsd_pkg::lsd_src_t sources;
  logic fault_out_n;
  logic [31:0] rd;
  logic err;
  int cnt;
  int miscompares = 0;
  int checked = 0;
  always #4 clock = ~clock;
  lsd_diag DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diag_disable_pin(diag_disable_pin),
    .enable_reset_pulse(enable_reset_pulse),
    .pwm_inputs(pwm_inputs), .freewheel_window(freewheel_window), .comps(comps),
    .sources(sources), .fault_out_n(fault_out_n));
  lsd_afe_model u_afe (.sources(sources), .freewheel_window(freewheel_window),
    .comps(comps), .open_pu(open_pu), .open_pd(open_pd), .short_sb(short_sb),
    .short_sg(short_sg), .load_ok(load_ok));
  // ************
  // shared tasks
  // ************
  task tally_and_finish;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20)
    begin
      miscompares++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // wait for one source line; the count feeds the step timing checks
  task waits(input int b, input logic v, input int lim);
    cnt = 0;
    while (sources[b] !== v && cnt < lim)
    begin
      @(posedge clock);
      cnt++;
    end
    if (cnt >= lim)
    begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  // ************
  // scenarios
  // ************
  task s_reset;
    chk("fault_n", 32'h1, fault_out_n);
    chk("sources", 32'h0, sources);
    apb(1'b0, A_CT, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, A_FL, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'h1, err);
  endtask
  task s_abort;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, A_CT, 32'h2);
      cyc(3);
      chk("gates_off", 32'h1, sources.gates_off);
      apb(1'b0, A_CT, 32'h0);
      chk("start_held", 32'h1, rd[lsd_pkg::CTRL_OLP_BIT]);
      if (k == 0)
        pwm_inputs <= pwm_inputs ^ 6'h01;
      else
        apb(1'b1, A_CT, 32'h0);
      waits(0, 1'b0, 20);
      apb(1'b0, A_CT, 32'h0);
      chk("start_abort", 32'h0, rd[lsd_pkg::CTRL_OLP_BIT]);
      chk("fault_abort", 32'h1, fault_out_n);
    end
  endtask
  task s_passive;
    open_pu <= 3'h3; // phase 1 trips only one comparator
    open_pd <= 3'h1;
    apb(1'b1, A_CT, 32'h2);
    waits(0, 1'b0, 70000);
    cyc(3);
    chk("ol_fault_n", 32'h0, fault_out_n);
    apb(1'b0, A_FL, 32'h0);
    chk("ol_flags", 32'h9, rd);
    apb(1'b0, A_ST, 32'h0);
    chk("ol_status", 32'h3, rd & 32'h3);
    open_pu <= 3'h0;
    open_pd <= 3'h0;
    enable_reset_pulse <= 1'b1;
    cyc(1);
    enable_reset_pulse <= 1'b0;
    cyc(6);
    chk("ol_cleared", 32'h1, fault_out_n);
    apb(1'b0, A_FL, 32'h0);
    chk("ol_flags_clr", 32'h0, rd & 32'h7);
  endtask
  task s_active;
    apb(1'b1, A_CT, 32'h8);
    for (int i = 0; i < 6; i++)
    begin
      load_ok[0] <= (i == 2); // one freewheel pulse resets the count
      freewheel_window[0] <= 1'b1;
      cyc(2);
      freewheel_window[0] <= 1'b0;
      cyc(2);
      if (i == 4)
        chk("ola_early", 32'h1, fault_out_n);
    end
    cyc(4);
    chk("ola_fault_n", 32'h0, fault_out_n);
    apb(1'b0, A_FL, 32'h0);
    chk("ola_flag", 32'h1, rd & 32'h1);
    load_ok <= 3'h7;
    apb(1'b1, A_CT, 32'h1);
    cyc(4);
    chk("ola_cleared", 32'h1, fault_out_n);
  endtask
  task s_pin;
    diag_disable_pin <= 1'b1;
    load_ok <= 3'h0;
    apb(1'b1, A_CT, 32'h10a);
    cyc(4);
    chk("pin_no_olp", 32'h0, sources.gates_off);
    for (int i = 0; i < 3; i++)
    begin
      freewheel_window[0] <= 1'b1;
      cyc(2);
      freewheel_window[0] <= 1'b0;
      cyc(2);
    end
    cyc(2);
    chk("pin_no_ola", 32'h1, fault_out_n);
    apb(1'b1, A_CT, 32'h0);
    diag_disable_pin <= 1'b0;
    load_ok <= 3'h7;
  endtask
  task s_short;
    short_sb <= 3'h2;
    short_sg <= 3'h4;
    apb(1'b1, A_CT, 32'h4);
    waits(2, 1'b1, 20);
    chk("sg_early", 32'h0, sources.source_pu_en);
    waits(1, 1'b1, 40000);
    chk("sb_time", 32'h1, cnt >= STEP - 2 && cnt <= STEP + 2);
    chk("sb_done", 32'h0, sources.drain_pd_en);
    chk("sb_fault_n", 32'h0, fault_out_n);
    apb(1'b0, A_FL, 32'h0);
    chk("sb_flags", 32'h420, rd & 32'h770);
    sys_rst <= 1'b1;
    cyc(6);
    sys_rst <= 1'b0;
    cyc(1);
    chk("rst_fault_n", 32'h1, fault_out_n);
    chk("rst_sources", 32'h0, sources);
  endtask
  initial
  begin
    cyc(6);
    sys_rst <= 1'b0;
    cyc(1);
    s_reset;
    s_abort;
    s_passive;
    s_active;
    s_pin;
    s_short;
    tally_and_finish;
  end
endmodule // load_and_short_diagnostics_bench
bind lsd_diag lsd_checker u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .enable_reset_pulse(enable_reset_pulse),
  .sources(sources), .fault_out_n(fault_out_n));

// ==== tb/lsd_afe_model.sv ====
module lsd_afe_model (
  // design side
  input wire lsd_pkg::lsd_src_t sources,
  input wire logic [2:0] freewheel_window,
  output lsd_pkg::lsd_comp_t comps,
  // load conditions set by the bench
  input wire logic [2:0] open_pu,
  input wire logic [2:0] open_pd,
  input wire logic [2:0] short_sb,
  input wire logic [2:0] short_sg,
  input wire logic [2:0] load_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // comparators
  // ************
  // a comparator whose source is off reads low, so no stale trip lingers
  assign comps = '{
    pullup_open_comparator: sources.pullup_src_en ? open_pu : 3'h0,
    pulldown_open_comparator: sources.pulldown_src_en ? open_pd : 3'h0,
    drain_short_comparator: sources.drain_pd_en ? short_sb : 3'h0,
    source_short_comparator: sources.source_pu_en ? short_sg : 3'h0,
    overshoot_comparator: freewheel_window & load_ok
  };
endmodule // lsd_afe_model

// ==== tb/lsd_checker.sv ====
module lsd_checker (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // bus and pins
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic enable_reset_pulse,
  input wire lsd_pkg::lsd_src_t sources,
  input wire logic fault_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] quiet_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ************
  // helper
  // ************
  // clear paths may pass a few flops, so latching is judged only when quiet
  always_ff @(posedge clock)
  begin
    if (sys_rst || psel || enable_reset_pulse)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  AST_GATES_OFF: assert property (
    (sources.pullup_src_en || sources.pulldown_src_en) |-> sources.gates_off)
    else $error("gates enabled during passive test");
  AST_PU_PD_EXCL: assert property (
    !(sources.pullup_src_en && sources.pulldown_src_en))
    else $error("pull-up and pull-down together");
  AST_PU_FIRST: assert property (
    $rose(sources.pulldown_src_en) |-> $past(sources.pullup_src_en))
    else $error("pull-down step without pull-up step");
  AST_SB_FIRST: assert property (
    $rose(sources.source_pu_en) |-> $past(sources.drain_pd_en))
    else $error("ground short step without supply step");
  AST_SB_SG_EXCL: assert property (
    !(sources.drain_pd_en && sources.source_pu_en))
    else $error("both short steps together");
  AST_FAULT_LATCH: assert property (
    (!fault_out_n && quiet_r == 3'h7) |=> !fault_out_n)
    else $error("fault pin released without clear");
  AST_PREADY: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
  AST_RESET_OUT: assert property (
    $fell(sys_rst) |-> (fault_out_n && sources == 5'h00))
    else $error("outputs not cleared by reset");
endmodule // lsd_checker
